/* rtl/ptu_top.sv */
// Purpose: eight-line port with edge detection and four timers
// Assumes: bus requests and pins are synchronous to clk_i
// Notes:   interrupt outputs are one-cycle pulses for the controller
`timescale 1ns/1ns
`default_nettype none
module ptu_top
  import ptu_pkg::*;
#(
  parameter int TCLK_DIV = 4
)(
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  // register bus
  input  wire ptu_bus_req_type bus_i,
  output logic [7:0]           rdata_o,
  output logic                 ack_o,
  // general port lines
  input  wire logic [7:0]      general_port_i,
  output logic [7:0]           general_port_o,
  output logic [7:0]           general_port_oe_o,
  // timer auxiliary inputs
  input  wire logic            timer_a_aux_input_i,
  input  wire logic            timer_b_aux_input_i,
  // timer outputs
  output logic [3:0]           timer_out_o,
  // interrupt source pulses
  output logic [7:0]           port_irq_o,
  output logic [3:0]           timer_irq_o
);

  // register state
  logic [7:0] port_data_bits;
  logic [7:0] edge_select_bits;
  logic [7:0] direction_bits;
  logic [3:0] ta_mode;
  logic [3:0] tb_mode;
  logic [2:0] tc_mode;
  logic [2:0] td_mode;

  // timer clock divider
  logic [7:0] tdiv_cnt;
  logic       tick;

  // decode and detector signals
  logic         wr_port;
  logic         wr_edge;
  logic         wr_dir;
  logic         wr_ta;
  logic         wr_tb;
  logic         wr_tcd;
  logic [3:0]   wr_data;
  logic [3:0]   clr_out;
  ptu_kind_type kind [4];
  logic [7:0]   next_rdata;
  logic [7:0]   det_level;
  logic [7:0]   det_prev;
  logic         gate_a;
  logic         gate_b;
  logic         aux_a_prev;
  logic         aux_b_prev;
  logic [1:0]   evt;
  logic [7:0]   cnt [4];
  logic [3:0]   tout;
  logic [3:0]   tout_level;

  localparam logic [7:0] TDIV_LAST = 8'(TCLK_DIV - 1);

  // address match helper
  function automatic logic hit(input logic [5:0] ofs);
    hit = bus_i.wr && (bus_i.addr == ofs);
  endfunction

  // write strobes from the address decode
  always_comb begin
    wr_port = 1'b0;
    wr_edge = 1'b0;
    wr_dir  = 1'b0;
    wr_ta   = 1'b0;
    wr_tb   = 1'b0;
    wr_tcd  = 1'b0;
    wr_data = 4'h0;
    if (hit(OFS_PORT_DATA)) begin
      wr_port = 1'b1;
    end else if (hit(OFS_EDGE_SEL)) begin
      wr_edge = 1'b1;
    end else if (hit(OFS_DIRECTION)) begin
      wr_dir = 1'b1;
    end else if (hit(OFS_TA_CTRL)) begin
      wr_ta = 1'b1;
    end else if (hit(OFS_TB_CTRL)) begin
      wr_tb = 1'b1;
    end else if (hit(OFS_TCD_CTRL)) begin
      wr_tcd = 1'b1;
    end else if (hit(OFS_TA_DATA)) begin
      wr_data[0] = 1'b1;
    end else if (hit(OFS_TB_DATA)) begin
      wr_data[1] = 1'b1;
    end else if (hit(OFS_TC_DATA)) begin
      wr_data[2] = 1'b1;
    end else if (hit(OFS_TD_DATA)) begin
      wr_data[3] = 1'b1;
    end
  end

  // output clear acts for the write cycle only, so a later time-out still toggles
  assign clr_out[0] = wr_ta && bus_i.wdata[BIT_CLR_OUT];
  assign clr_out[1] = wr_tb && bus_i.wdata[BIT_CLR_OUT];
  assign clr_out[2] = 1'b0;
  assign clr_out[3] = 1'b0;

  // port data register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_data_bits <= RST_BYTE;
    end else if (wr_port) begin
      port_data_bits <= bus_i.wdata;
    end
  end

  // edge select register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      edge_select_bits <= RST_BYTE;
    end else if (wr_edge) begin
      edge_select_bits <= bus_i.wdata;
    end
  end

  // direction register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      direction_bits <= RST_BYTE;
    end else if (wr_dir) begin
      direction_bits <= bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ta_mode <= RST_MODE;
      tb_mode <= RST_MODE;
      tc_mode <= RST_MODE[2:0];
      td_mode <= RST_MODE[2:0];
    end else begin
      if (wr_ta) begin
        ta_mode <= bus_i.wdata[3:0];
      end
      if (wr_tb) begin
        tb_mode <= bus_i.wdata[3:0];
      end
      if (wr_tcd) begin
        tc_mode <= bus_i.wdata[6:4];
        td_mode <= bus_i.wdata[2:0];
      end
    end
  end

  // C and D limited to stop and delay codes
  assign kind[0] = ptu_kind(ta_mode);
  assign kind[1] = ptu_kind(tb_mode);
  assign kind[2] = ptu_kind({1'b0, tc_mode});
  assign kind[3] = ptu_kind({1'b0, td_mode});

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      general_port_o    <= RST_BYTE;
      general_port_oe_o <= RST_BYTE;
    end else begin
      general_port_o    <= port_data_bits;
      general_port_oe_o <= direction_bits;
    end
  end

  // read mux; unmapped and unused bits read zero
  always_comb begin
    next_rdata = RST_BYTE;
    if (bus_i.addr == OFS_PORT_DATA) begin
      // outputs from register, inputs from pins
      next_rdata = (port_data_bits & direction_bits) | (general_port_i & ~direction_bits);
    end else if (bus_i.addr == OFS_EDGE_SEL) begin
      next_rdata = edge_select_bits;
    end else if (bus_i.addr == OFS_DIRECTION) begin
      next_rdata = direction_bits;
    end else if (bus_i.addr == OFS_TA_CTRL) begin
      next_rdata = {4'h0, ta_mode};
    end else if (bus_i.addr == OFS_TB_CTRL) begin
      next_rdata = {4'h0, tb_mode};
    end else if (bus_i.addr == OFS_TCD_CTRL) begin
      next_rdata = {1'b0, tc_mode, 1'b0, td_mode};
    end else if (bus_i.addr == OFS_TA_DATA) begin
      next_rdata = cnt[0];
    end else if (bus_i.addr == OFS_TB_DATA) begin
      next_rdata = cnt[1];
    end else if (bus_i.addr == OFS_TC_DATA) begin
      next_rdata = cnt[2];
    end else if (bus_i.addr == OFS_TD_DATA) begin
      next_rdata = cnt[3];
    end
  end

  // read data held until the next read; ack one cycle after any request
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= RST_BYTE;
      ack_o   <= 1'b0;
    end else begin
      ack_o <= bus_i.rd || bus_i.wr;
      if (bus_i.rd) begin
        rdata_o <= next_rdata;
      end
    end
  end

  // common timer clock enable from the system clock
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tdiv_cnt <= RST_BYTE;
      tick     <= 1'b0;
    end else begin
      tick     <= tdiv_cnt == TDIV_LAST;
      tdiv_cnt <= (tdiv_cnt == TDIV_LAST) ? RST_BYTE : tdiv_cnt + 8'h01;
    end
  end

  // aux active when it equals the edge bit
  assign gate_a = ~(timer_a_aux_input_i ^ edge_select_bits[LINE_FOUR]);
  assign gate_b = ~(timer_b_aux_input_i ^ edge_select_bits[LINE_THREE]);

  // aux history for event counting; starts high so a level already active is no count
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aux_a_prev <= 1'b1;
      aux_b_prev <= 1'b1;
    end else begin
      aux_a_prev <= gate_a;
      aux_b_prev <= gate_b;
    end
  end

  // active transition of the aux input counts in event mode
  assign evt[0] = gate_a && !aux_a_prev;
  assign evt[1] = gate_b && !aux_b_prev;

  always_comb begin
    det_level = general_port_i ^ edge_select_bits;
    // pulse mode reroutes and inverts lines four and three
    if (kind[0] == KIND_PULSE) begin
      det_level[LINE_FOUR] = gate_a;
    end
    if (kind[1] == KIND_PULSE) begin
      det_level[LINE_THREE] = gate_b;
    end
  end

  // interrupt on a fall of the detector level
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      det_prev   <= RST_BYTE;
      port_irq_o <= RST_BYTE;
    end else begin
      det_prev   <= det_level;
      port_irq_o <= det_prev & ~det_level;
    end
  end

  // four timers, C and D without aux or event input
  for (genvar g = 0; g < 4; g++) begin : g_tmr
    ptu_timer u_tmr (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .tick_i    (tick),
      .kind_i    (kind[g]),
      .div_sel_i ((g == 0) ? ta_mode[2:0] : (g == 1) ? tb_mode[2:0] : (g == 2) ? tc_mode : td_mode),
      .gate_i    ((g == 0) ? gate_a : (g == 1) ? gate_b : 1'b0),
      .evt_i     ((g == 0) ? evt[0] : (g == 1) ? evt[1] : 1'b0),
      .wr_i      (wr_data[g]),
      .wdata_i   (bus_i.wdata),
      .clr_out_i (clr_out[g]),
      .cnt_o     (cnt[g]),
      .tout_o    (tout[g]),
      .out_o     (tout_level[g])
    );
  end

  // registered time-out pulses and output levels
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_irq_o <= 4'h0;
      timer_out_o <= 4'h0;
    end else begin
      timer_irq_o <= tout;
      timer_out_o <= tout_level;
    end
  end

endmodule
`default_nettype wire

/* rtl/ptu_pkg.sv */
// Purpose: shared constants and types for the port and timer unit
// Assumes: byte-wide register bus, one 10 MHz clock
// Notes:   offsets are byte addresses of the peripheral bus
package ptu_pkg;

  // register offsets
  localparam logic [5:0] OFS_PORT_DATA = 6'h01;
  localparam logic [5:0] OFS_EDGE_SEL  = 6'h03;
  localparam logic [5:0] OFS_DIRECTION = 6'h05;
  localparam logic [5:0] OFS_TA_CTRL   = 6'h19;
  localparam logic [5:0] OFS_TB_CTRL   = 6'h1B;
  localparam logic [5:0] OFS_TCD_CTRL  = 6'h1D;
  localparam logic [5:0] OFS_TA_DATA   = 6'h1F;
  localparam logic [5:0] OFS_TB_DATA   = 6'h21;
  localparam logic [5:0] OFS_TC_DATA   = 6'h23;
  localparam logic [5:0] OFS_TD_DATA   = 6'h25;

  // reset values and field positions
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [3:0] RST_MODE      = 4'h0;
  localparam int         BIT_CLR_OUT   = 4;
  localparam int         LINE_FOUR     = 4;
  localparam int         LINE_THREE    = 3;
  localparam logic [7:0] CNT_LAST      = 8'h01;
  localparam logic [3:0] MODE_EVENT    = 4'h8;

  // prescaler ratios
  localparam logic [7:0] DIV_4   = 8'h04;
  localparam logic [7:0] DIV_10  = 8'h0A;
  localparam logic [7:0] DIV_16  = 8'h10;
  localparam logic [7:0] DIV_50  = 8'h32;
  localparam logic [7:0] DIV_64  = 8'h40;
  localparam logic [7:0] DIV_100 = 8'h64;
  localparam logic [7:0] DIV_200 = 8'hC8;

  // timer operating kind, gray along stop-delay-pulse-event
  typedef enum logic [1:0] {
    KIND_STOP  = 2'b00,
    KIND_DELAY = 2'b01,
    KIND_PULSE = 2'b11,
    KIND_EVENT = 2'b10
  } ptu_kind_type;

  // register bus request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ptu_bus_req_type;

  // prescaler ratio from the three low mode bits
  function automatic logic [7:0] ptu_div(input logic [2:0] sel);
    case (sel)
      3'h2:    ptu_div = DIV_10;
      3'h3:    ptu_div = DIV_16;
      3'h4:    ptu_div = DIV_50;
      3'h5:    ptu_div = DIV_64;
      3'h6:    ptu_div = DIV_100;
      3'h7:    ptu_div = DIV_200;
      default: ptu_div = DIV_4;
    endcase
  endfunction

  // operating kind from a four-bit mode code
  function automatic ptu_kind_type ptu_kind(input logic [3:0] code);
    if (code == RST_MODE) begin
      ptu_kind = KIND_STOP;
    end else if (!code[3]) begin
      ptu_kind = KIND_DELAY;
    end else if (code == MODE_EVENT) begin
      ptu_kind = KIND_EVENT;
    end else begin
      ptu_kind = KIND_PULSE;
    end
  endfunction

endpackage

/* rtl/ptu_timer.sv */
// Purpose: one 8-bit prescaler and down-counter timer channel
// Assumes: tick_i is a one-cycle timer clock enable
// Notes:   kind comes decoded from the control register; the divider select is decoded here
`timescale 1ns/1ns
`default_nettype none
module ptu_timer
  import ptu_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // control
  input  wire logic         tick_i,
  input  wire ptu_kind_type kind_i,
  input  wire logic [2:0]   div_sel_i,
  input  wire logic         gate_i,
  input  wire logic         evt_i,
  input  wire logic         wr_i,
  input  wire logic [7:0]   wdata_i,
  input  wire logic         clr_out_i,
  // status
  output logic [7:0]        cnt_o,
  output logic              tout_o,
  output logic              out_o
);

  logic [7:0] pre;
  logic [7:0] reload;
  logic [7:0] div_m1;
  logic       run;
  logic       pre_end;
  logic       cpulse;

  assign run     = (kind_i == KIND_DELAY) || (kind_i == KIND_PULSE && gate_i);
  assign div_m1  = ptu_div(div_sel_i) - CNT_LAST;
  // odd first period
  // a ratio cut below the count already held ends at once, giving the short first period
  assign pre_end = pre >= div_m1;
  assign cpulse  = (kind_i == KIND_EVENT) ? evt_i : (run && tick_i && pre_end);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre <= RST_BYTE;
    end else if (!run) begin
      pre <= RST_BYTE;
    end else if (tick_i) begin
      pre <= pre_end ? RST_BYTE : pre + CNT_LAST;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reload <= RST_BYTE;
    end else if (wr_i) begin
      reload <= wdata_i;
    end
  end

  // reload at 01, 00 wraps to 256 pulses
  // running rewrites wait for the 01 pass
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_o <= RST_BYTE;
    end else if (wr_i && kind_i == KIND_STOP) begin
      cnt_o <= wdata_i;
    end else if (cpulse) begin
      cnt_o <= (cnt_o == CNT_LAST) ? reload : cnt_o - CNT_LAST;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tout_o <= 1'b0;
      out_o  <= 1'b0;
    end else begin
      tout_o <= cpulse && (cnt_o == CNT_LAST);
      if (clr_out_i) begin
        out_o <= 1'b0;
      end else if (cpulse && cnt_o == CNT_LAST) begin
        out_o <= ~out_o;
      end
    end
  end

endmodule
`default_nettype wire

/* tb/ptu_monitor.sv */
// Purpose: port-level checker for the port and timer unit
// Assumes: the timer output clear bit is never written
// Notes:   bound to every ptu_top instance
`timescale 1ns/1ns
`default_nettype none
module ptu_monitor
  import ptu_pkg::*;
(
  // clock and reset
  input wire logic            clk_i,
  input wire logic            rst_b_i,
  // bus and outputs
  input wire ptu_bus_req_type bus_i,
  input wire logic [7:0]      rdata_o,
  input wire logic            ack_o,
  input wire logic [7:0]      general_port_o,
  input wire logic [7:0]      general_port_oe_o,
  input wire logic [3:0]      timer_out_o,
  input wire logic [7:0]      port_irq_o,
  input wire logic [3:0]      timer_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // writes to the port registers
  wire logic wr_dat = bus_i.wr && bus_i.addr == OFS_PORT_DATA;
  wire logic wr_dir = bus_i.wr && bus_i.addr == OFS_DIRECTION;

  AST_ACK: assert property (ack_o == $past(bus_i.rd || bus_i.wr))
    else $error("ack not one cycle after request");
  AST_HOLD: assert property (!bus_i.rd |=> $stable(rdata_o))
    else $error("read data moved without a read");
  AST_UNMAP: assert property (bus_i.rd && bus_i.addr == 6'h3F |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_OUT: assert property (wr_dat |-> ##2 general_port_o == $past(bus_i.wdata, 2))
    else $error("port data not driven");
  AST_DIR: assert property (wr_dir ##1 !wr_dir |=> general_port_oe_o == $past(bus_i.wdata, 2))
    else $error("direction not applied");
  // three quiet cycles cover a one-cycle-late enable
  AST_DIR_KEEP: assert property (!wr_dir [*3] |-> $stable(general_port_oe_o))
    else $error("enable moved without a write");
  AST_TOGGLE: assert property (timer_irq_o == (timer_out_o ^ $past(timer_out_o)))
    else $error("timer output and time-out disagree");
  AST_TPULSE: assert property (timer_irq_o != 4'h0 |=> (timer_irq_o & $past(timer_irq_o)) == 4'h0)
    else $error("time-out wider than one cycle");
  AST_PPULSE: assert property (port_irq_o != 8'h00 |=> (port_irq_o & $past(port_irq_o)) == 8'h00)
    else $error("port pulse wider than one cycle");

  // main scenarios reached
  COV_TA: cover property (timer_irq_o[0]);
  COV_TD: cover property (timer_irq_o[3]);
  COV_P4: cover property (port_irq_o[4]);
endmodule
`default_nettype wire

bind ptu_top ptu_monitor i_mon (.clk_i, .rst_b_i, .bus_i, .rdata_o, .ack_o, .general_port_o,
  .general_port_oe_o, .timer_out_o, .port_irq_o, .timer_irq_o);

/* tb/ptu_host.sv */
// Purpose: host processor model on the register bus
// Assumes: a request is a one-cycle pulse answered by ack
// Notes:   drives at a falling edge, takes the registered answer at the next falling edge
`timescale 1ns/1ns
`default_nettype none
module ptu_host
  import ptu_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // answer side
  input  wire logic        ack_i,
  input  wire logic [7:0]  rdata_i,
  // request side
  output ptu_bus_req_type  bus_o,
  output logic             hang_o
);
  // idle bus at time zero
  initial begin
    bus_o  = '0;
    hang_o = 1'b0;
  end
  // one request; ack and read data are registered, so they are taken settled at the
  // falling edge after the taking edge; holding longer would issue a second request
  task automatic cyc(input logic r, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(negedge clk_i);
    bus_o = '{rd: r, wr: !r, addr: a, wdata: d};
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 8);
    q = rdata_i;
    // released fields show inverted junk
    bus_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    if (ack_i !== 1'b1) begin
      hang_o = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

/* tb/ptu_top_bench.sv */
// Purpose: self-checking bench for the port and timer unit
// Assumes: timer clock every cycle to keep runs short
// Notes:   the output clear bit is left alone
`timescale 1ns/1ns
`default_nettype none
module ptu_top_bench
  import ptu_pkg::*;
;
  localparam int TD = 1;
  logic            clk_i, rst_b_i, aux_a, aux_b, ack, hang;
  logic [7:0]      ext, pin, rdata, oe, pout, pirq, q, d, v, e;
  logic [3:0]      tout, tirq;
  ptu_bus_req_type bus;
  int              bad_count = 0, checked = 0, seed = 32'h89042e8f;
  int              divs[8] = '{0, 4, 10, 16, 50, 64, 100, 200};

  // driven lines override the outside level
  assign pin = (oe & pout) | (~oe & ext);

  ptu_host i_host (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata), .bus_o(bus), .hang_o(hang));
  ptu_top #(.TCLK_DIV(TD)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
    .ack_o(ack), .general_port_i(pin), .general_port_o(pout), .general_port_oe_o(oe),
    .timer_a_aux_input_i(aux_a), .timer_b_aux_input_i(aux_b), .timer_out_o(tout),
    .port_irq_o(pirq), .timer_irq_o(tirq));

  // expected figures
  function automatic int gap_of(input int code, input int rel);
    return divs[code] * (rel == 0 ? 256 : rel) * TD;
  endfunction
  function automatic logic [7:0] port_rd(input logic [7:0] dd, vv, ee);
    return (vv & dd) | (ee & ~dd);
  endfunction

  task automatic chk(input logic [15:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] dd);
    i_host.cyc(1'b0, a, dd, q);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] x, input string w);
    i_host.cyc(1'b1, a, 8'h00, q);
    chk(q, x, w);
  endtask
  // gather port pulses over a window
  task automatic watch(input int n, input logic [7:0] x, input string w);
    logic [7:0] m;
    m = 8'h00;
    repeat (n) begin
      @(negedge clk_i);
      m = m | pirq;
    end
    chk(m, x, w);
  endtask
  // pulse-to-pulse spacing; the first period may be odd after a change
  task automatic gap(input int b, input int x, input string w);
    int   n;
    logic t;
    n = 0;
    while (tirq[b] !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    t = tout[b];
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (tirq[b] !== 1'b1 && n < 3000);
    // a missing time-out is a mismatch and ends the run
    if (n >= 3000) begin
      bad_count++;
      end_of_test();
    end
    chk(16'(n), 16'(x), w);
    chk(16'(tout[b]), 16'(!t), "timer output toggle");
  endtask

  // a stuck wait ends the run at once
  always @(posedge hang) begin
    bad_count++;
    end_of_test();
  end
  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // main sequence
  initial begin
    rst_b_i = 1'b0;
    ext = 8'h00;
    aux_a = 1'b0;
    aux_b = 1'b0;
    cy(20);
    rst_b_i = 1'b1;
    chk(oe, 8'h00, "enable at reset");
    rdc(OFS_DIRECTION, RST_BYTE, "direction reset");
    rdc(OFS_EDGE_SEL, RST_BYTE, "edge reset");
    rdc(OFS_PORT_DATA, RST_BYTE, "data reset");
    rdc(6'h3F, 8'h00, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      d = i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($random(seed));
      v = 8'($random(seed));
      e = 8'($random(seed));
      wr(OFS_DIRECTION, d);
      wr(OFS_PORT_DATA, v);
      cy(1);
      ext = e;
      cy(3);
      chk(oe, d, "enable");
      chk(pout, v, "drive");
      rdc(OFS_PORT_DATA, port_rd(d, v, e), "port read");
    end
    wr(OFS_DIRECTION, 8'h00);
    wr(OFS_EDGE_SEL, 8'h00);
    cy(1);
    ext = 8'h00;
    cy(6);
    ext = 8'hFF;
    watch(6, 8'h00, "rise on falling select");
    ext = 8'h00;
    watch(6, 8'hFF, "fall on falling select");
    wr(OFS_EDGE_SEL, 8'hFF);
    watch(6, 8'h00, "edge write, level up");
    ext = 8'hFF;
    watch(6, 8'hFF, "rise on rising select");
    wr(OFS_EDGE_SEL, 8'h00);
    watch(6, 8'h00, "edge clear, level up");
    wr(OFS_EDGE_SEL, 8'hFF);
    watch(6, 8'hFF, "edge set gives pulse");
    wr(OFS_TC_DATA, 8'h01);
    for (int c = 1; c < 8; c++) begin
      wr(OFS_TCD_CTRL, 8'(c << 4));
      gap(2, gap_of(c, 1), "timer c period");
    end
    wr(OFS_TCD_CTRL, 8'h01);
    wr(OFS_TD_DATA, 8'h00);
    gap(3, gap_of(1, 0), "reload 00 period");
    wr(OFS_TCD_CTRL, 8'h00);
    wr(OFS_TA_DATA, 8'h03);
    wr(OFS_TA_CTRL, 8'h01);
    gap(0, gap_of(1, 3), "reload 03 period");
    wr(OFS_TA_DATA, 8'h02);
    gap(0, gap_of(1, 2), "rewrite at 01 pass");
    wr(OFS_TA_CTRL, 8'h00);
    i_host.cyc(1'b1, OFS_TA_DATA, 8'h00, q);
    v = q;
    cy(20);
    rdc(OFS_TA_DATA, v, "stopped count kept");
    wr(OFS_TB_DATA, 8'h5A);
    rdc(OFS_TB_DATA, 8'h5A, "stopped load");
    // edge bits set before the mode
    wr(OFS_EDGE_SEL, 8'h10);
    cy(1);
    ext = 8'h00;
    wr(OFS_TA_DATA, 8'h00);
    wr(OFS_TA_CTRL, 8'h09);
    cy(8);
    ext = 8'h10;
    watch(6, 8'h00, "line four detached");
    rdc(OFS_TA_DATA, 8'h00, "gate closed");
    cy(1);
    // counter set before the pulse starts
    aux_a = 1'b1;
    watch(40, 8'h00, "pulse start quiet");
    aux_a = 1'b0;
    watch(6, 8'h10, "pulse end pulse");
    i_host.cyc(1'b1, OFS_TA_DATA, 8'h00, q);
    chk(16'(q >= 8'hF5 && q <= 8'hF7), 16'h0001, "pulse width count");
    wr(OFS_TA_CTRL, 8'h00);
    cy(1);
    ext = 8'h00;
    cy(6);
    ext = 8'h10;
    watch(6, 8'h10, "normal polarity back");
    end_of_test();
  end
endmodule
`default_nettype wire
